// >>> verilog/osw_map.svh
// Address map, field positions, codes and counts of the oscillator switch block.
// Assumes it is included by bare name from the design files.
`ifndef OSW_MAP_SVH
`define OSW_MAP_SVH
`define OSW_ADR_CTRL     8'h00
`define OSW_F_CUR        14:12
`define OSW_F_NEXT       10:8
`define OSW_B_FREEZE     7
`define OSW_B_SETTLED    5
`define OSW_B_FAIL       3
`define OSW_B_DRV        2
`define OSW_B_AUXEN      1
`define OSW_B_REQ        0
`define OSW_SEL_LOW      0
`define OSW_SEL_HIGH     1
`define OSW_SRC_FAST     3'h0
`define OSW_SRC_FAST_PLL 3'h1
`define OSW_SRC_MAIN     3'h2
`define OSW_SRC_MAIN_PLL 3'h3
`define OSW_SRC_AUX      3'h4
`define OSW_SRC_LOWRC    3'h5
`define OSW_SRC_FAST_DIV 3'h7
`define OSW_SETTLE_EDGES 4'hA
`define OSW_INIT_CYC     2'h3
`define OSW_RST_SRC      3'h0
`endif

// >>> verilog/osw_pkg.sv
// Types shared by the oscillator switch block.
// Assumes the map header is compiled alongside.
package osw_pkg;
    typedef enum logic [2:0] {
        OSW_IDLE   = 3'h0,
        OSW_START  = 3'h1,
        OSW_READY  = 3'h2,
        OSW_SETTLE = 3'h3,
        OSW_DONE   = 3'h4
    } osw_state_t;
endpackage

// >>> verilog/osw_ctrl.sv
// Oscillator control register and clock-switch sequencer, Wishbone classic slave.
// Assumes fuse, oscillator status and new-clock inputs are asynchronous and slow.
// Notes on behaviour
// RULE1: Monitor enabled and freeze set: no source change, switch request refused.
// RULE2: Monitor disabled: selections never frozen, switching always possible. The code holds request at zero then and never switches.
// RULE3: Settled flag is one when PLL locked or its timer done, else zero.
// RULE4: Settled flag forced zero during valid switch and in non-PLL modes.
// RULE5: Clock-fail flag set on monitor-detected failure, zero while none seen.
// RULE6: Drive bit one selects high power; zero defers to source fuse. The code selects low power then, whatever the fuse.
// RULE7: With digital clock input selected, drive bit has no effect.
// RULE8: Aux enable bit turns the secondary oscillator on and off.
// RULE9: Writing one to request starts switch to next source; reads zero when done.
// RULE10: Source fields load from the initial-source fuses after reset.
// RULE11: Switching among main, aux, fast RC and low-power RC at any time.
// RULE12: Main submode fixed by fuses; switching never changes it.
// RULE13: Bits six and four always read zero.
// RULE14: Request with next equal current clears request and aborts.
// RULE15: After new source ready, wait ten new-clock cycles before switching.
// RULE16: On success clear request, copy next to current, stop old source.
// RULE17: Switch-monitor fuse unprogrammed disables switching, request held zero.
// RULE18: Clock-fail flag sticky until software clears it; offered as event. The code also clears it when a switch starts.
//
// The placing of the registers and register access over Wishbone were left to the implementer.
`timescale 1ns/10ps
`include "osw_map.svh"
module osw_ctrl (
    input  wire logic              clk,
    input  wire logic              reset,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [7:0]        wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    input  wire logic [2:0]        initial_source_fuse,
    input  wire logic              switch_monitor_fuse,
    input  wire logic              aux_osc_source_fuse,
    input  wire logic [1:0]        main_osc_submode_fuse,
    input  wire logic              pll_lock,
    input  wire logic              startup_timer_done,
    input  wire logic              clock_failure,
    input  wire logic              lowrc_keep,
    input  wire logic              new_clk,
    output logic [2:0]             clock_select,
    output logic                   main_osc_en,
    output logic                   aux_osc_en,
    output logic                   fast_rc_osc_en,
    output logic                   low_power_rc_osc_en,
    output logic                   pll_en,
    output logic                   aux_osc_high_power,
    output logic [1:0]             main_osc_submode,
    output logic                   clock_fail_event,
    output osw_pkg::osw_state_t    switch_state
);
    import osw_pkg::*;

    logic [9:0]  meta_q;
    logic [9:0]  sync_q;
    logic        new_clk_q;
    logic [2:0]  fuse_src;
    logic        fuse_swm;
    logic        fuse_auxsrc;
    logic [1:0]  fuse_sub;
    logic        lock_s;
    logic        timer_s;
    logic        fail_s;
    logic        keep_s;
    logic        new_clk_s;
    logic        new_edge;
    logic [1:0]  init_cnt_q;
    logic        init_done;
    logic [2:0]  cur_q;
    logic [2:0]  next_q;
    logic        freeze_q;
    logic        settled_q;
    logic        fail_q;
    logic        drv_q;
    logic        auxen_q;
    logic        req_q;
    logic [3:0]  edges_q;
    osw_state_t  state_q;
    osw_state_t  state_d;
    logic        monitor_on;
    logic        frozen;
    logic        wr_hit;
    logic        wr_low;
    logic        wr_high;
    logic        busy;
    logic        pll_mode;
    logic [15:0] ctrl_rd;
    logic        settled_d;
    logic [3:0]  need_cur;
    logic [3:0]  need_new;
    logic [3:0]  osc_on_d;

    // One-hot of oscillators a source needs: {lowrc, fast, aux, main}
    function automatic logic [3:0] src_need(input logic [2:0] s);
        logic [3:0] n;
        n = 4'h0;
        if (s == `OSW_SRC_MAIN || s == `OSW_SRC_MAIN_PLL) begin
            n = 4'h1;
        end else if (s == `OSW_SRC_AUX) begin
            n = 4'h2;
        end else if (s == `OSW_SRC_LOWRC) begin
            n = 4'h8;
        end else begin
            n = 4'h4;
        end
        return n;
    endfunction

    function automatic logic src_pll(input logic [2:0] s);
        return (s == `OSW_SRC_FAST_PLL) || (s == `OSW_SRC_MAIN_PLL);
    endfunction

    // Two-stage synchronisers for every asynchronous input
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            meta_q <= 10'h000;
            sync_q <= 10'h000;
        end else begin
            meta_q <= {new_clk, lowrc_keep, clock_failure, startup_timer_done, pll_lock,
                       main_osc_submode_fuse, aux_osc_source_fuse, switch_monitor_fuse,
                       initial_source_fuse[0]};
            sync_q <= meta_q;
        end
    end

    // Fuse source bits 2:1 have their own pair; the ten-bit vector above carries only bit 0
    logic [1:0] fsrc_meta_q;
    logic [1:0] fsrc_sync_q;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            fsrc_meta_q <= 2'h0;
            fsrc_sync_q <= 2'h0;
        end else begin
            fsrc_meta_q <= initial_source_fuse[2:1];
            fsrc_sync_q <= fsrc_meta_q;
        end
    end

    assign fuse_src    = {fsrc_sync_q, sync_q[0]};
    assign fuse_swm    = sync_q[1];
    assign fuse_auxsrc = sync_q[2];
    assign fuse_sub    = sync_q[4:3];
    assign lock_s      = sync_q[5];
    assign timer_s     = sync_q[6];
    assign fail_s      = sync_q[7];
    assign keep_s      = sync_q[8];
    assign new_clk_s   = sync_q[9];

    // Edge of the new source clock, taken after the synchroniser only
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            new_clk_q <= 1'b0;
        end else begin
            new_clk_q <= new_clk_s;
        end
    end
    assign new_edge = new_clk_s & ~new_clk_q;

    // Fuses are caught once the synchronisers have filled after release
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            init_cnt_q <= 2'h0;
        end else if (init_cnt_q != `OSW_INIT_CYC) begin
            init_cnt_q <= init_cnt_q + 2'h1;
        end
    end
    assign init_done = (init_cnt_q == `OSW_INIT_CYC);

    // Monitor is on when the fuse is programmed low; freeze only bites then
    assign monitor_on = ~fuse_swm & init_done;
    assign frozen     = monitor_on & freeze_q;                        // [RULE1] [RULE2]
    assign busy       = (state_q != OSW_IDLE);
    assign pll_mode   = src_pll(cur_q);
    assign wr_hit     = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & (wb_adr_i == `OSW_ADR_CTRL);
    assign wr_low     = wr_hit & wb_sel_i[`OSW_SEL_LOW];
    assign wr_high    = wr_hit & wb_sel_i[`OSW_SEL_HIGH];

    // Readback; unused bit positions are constant zero
    always_comb begin
        ctrl_rd = 16'h0000;                                           // [RULE13]
        ctrl_rd[`OSW_F_CUR]     = cur_q;
        ctrl_rd[`OSW_F_NEXT]    = next_q;
        ctrl_rd[`OSW_B_FREEZE]  = freeze_q;
        ctrl_rd[`OSW_B_SETTLED] = settled_q;
        ctrl_rd[`OSW_B_FAIL]    = fail_q;
        ctrl_rd[`OSW_B_DRV]     = drv_q;
        ctrl_rd[`OSW_B_AUXEN]   = auxen_q;
        ctrl_rd[`OSW_B_REQ]     = req_q;
    end

    // Wishbone answer one cycle after the strobe; unmapped reads return zero
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
            if (wb_adr_i == `OSW_ADR_CTRL) begin
                wb_dat_o <= {16'h0000, ctrl_rd};
            end else begin
                wb_dat_o <= 32'h00000000;
            end
        end
    end

    // Low-byte control bits written by software
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            freeze_q <= 1'b0;
            drv_q    <= 1'b0;
            auxen_q  <= 1'b0;
        end else if (wr_low) begin
            freeze_q <= wb_dat_i[`OSW_B_FREEZE];
            drv_q    <= wb_dat_i[`OSW_B_DRV];
            auxen_q  <= wb_dat_i[`OSW_B_AUXEN];
        end
    end

    // Source fields: fuse copy at start-up, next editable only when idle and unfrozen
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cur_q  <= `OSW_RST_SRC;
            next_q <= `OSW_RST_SRC;
        end else if (!init_done || fuse_swm) begin
            cur_q  <= fuse_src;                                       // [RULE10] [RULE17]
            next_q <= fuse_src;
        end else if (state_q == OSW_DONE) begin
            cur_q <= next_q;                                          // [RULE16]
        end else if (wr_high && !busy && !frozen) begin
            next_q <= wb_dat_i[`OSW_F_NEXT];                          // [RULE11]
        end
    end

    // Switch request: set by software, cleared by hardware on abort or success
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            req_q <= 1'b0;
        end else if (!monitor_on) begin
            req_q <= 1'b0;                                            // [RULE17]
        end else if (state_q == OSW_DONE) begin
            req_q <= 1'b0;                                            // [RULE9] [RULE16]
        end else if (state_q == OSW_IDLE && req_q && next_q == cur_q) begin
            req_q <= 1'b0;                                            // [RULE14]
        end else if (wr_low && wb_dat_i[`OSW_B_REQ] && !frozen) begin
            req_q <= 1'b1;                                            // [RULE9] [RULE1]
        end
    end

    // Sequencer: start, wait for the new source, count its edges, switch
    always_comb begin
        state_d = state_q;
        case (state_q)
            OSW_IDLE: begin
                if (req_q && next_q != cur_q && monitor_on) begin
                    state_d = OSW_START;
                end
            end
            OSW_START: begin
                state_d = OSW_READY;
            end
            OSW_READY: begin
                if (timer_s && (!src_pll(next_q) || lock_s)) begin
                    state_d = OSW_SETTLE;
                end
            end
            OSW_SETTLE: begin
                if (new_edge && edges_q == `OSW_SETTLE_EDGES - 4'h1) begin
                    state_d = OSW_DONE;                               // [RULE15]
                end
            end
            OSW_DONE: begin
                state_d = OSW_IDLE;
            end
            default: begin
                state_d = OSW_IDLE;
            end
        endcase
        // A fuse that disables switching also abandons a switch in progress
        if (!monitor_on) begin
            state_d = OSW_IDLE;                                       // [RULE17]
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_q <= OSW_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // New-clock edge counter, live only while settling
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            edges_q <= 4'h0;
        end else if (state_q != OSW_SETTLE) begin
            edges_q <= 4'h0;
        end else if (new_edge) begin
            edges_q <= edges_q + 4'h1;                                // [RULE15]
        end
    end

    // Settled flag follows lock or timer, held low while switching or without PLL
    assign settled_d = pll_mode && !busy && (lock_s || timer_s);      // [RULE3] [RULE4]
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            settled_q <= 1'b0;
        end else begin
            settled_q <= settled_d;
        end
    end

    // Sticky fail flag; a new failure beats a software clear in the same cycle
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            fail_q           <= 1'b0;
            clock_fail_event <= 1'b0;
        end else begin
            clock_fail_event <= monitor_on & fail_s & ~fail_q;       // [RULE18]
            if (monitor_on && fail_s) begin
                fail_q <= 1'b1;                                       // [RULE5]
            end else if (state_q == OSW_START) begin
                fail_q <= 1'b0;
            end else if (wr_low && !wb_dat_i[`OSW_B_FAIL]) begin
                fail_q <= 1'b0;                                       // [RULE18]
            end
        end
    end

    // Oscillator enables: current source, incoming source while busy, and keeps
    assign need_cur = src_need(cur_q);
    assign need_new = busy ? src_need(next_q) : 4'h0;
    assign osc_on_d = need_cur | need_new | {keep_s, 1'b0, auxen_q, 1'b0};  // [RULE8] [RULE16]
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            main_osc_en         <= 1'b0;
            aux_osc_en          <= 1'b0;
            fast_rc_osc_en      <= 1'b0;
            low_power_rc_osc_en <= 1'b0;
            pll_en              <= 1'b0;
            aux_osc_high_power  <= 1'b0;
            clock_select        <= `OSW_RST_SRC;
            main_osc_submode    <= 2'h0;
            switch_state        <= OSW_IDLE;
        end else begin
            main_osc_en         <= osc_on_d[0];
            aux_osc_en          <= osc_on_d[1];
            fast_rc_osc_en      <= osc_on_d[2];
            low_power_rc_osc_en <= osc_on_d[3];
            pll_en              <= pll_mode | (busy & src_pll(next_q));
            // Digital clock input ignores drive strength entirely
            aux_osc_high_power  <= fuse_auxsrc & drv_q;               // [RULE6] [RULE7]
            clock_select        <= cur_q;
            main_osc_submode    <= fuse_sub;                          // [RULE12]
            switch_state        <= state_q;
        end
    end

    // Checks
    a_freeze_blocks_req: assert property (@(posedge clk) disable iff (reset) // [RULE1]
        (state_q == OSW_IDLE && frozen && !req_q) |=> !req_q)
        else $error("request set while frozen");
    a_unfrozen_req_set: assert property (@(posedge clk) disable iff (reset) // [RULE2]
        (!fuse_swm && !freeze_q && init_done && wr_low && wb_dat_i[`OSW_B_REQ]
         && state_q == OSW_IDLE) |=> req_q)
        else $error("request not taken when unfrozen");
    a_settled_zero_busy: assert property (@(posedge clk) disable iff (reset) // [RULE4]
        busy |=> !settled_q)
        else $error("settled flag high during switch");
    a_settled_follows: assert property (@(posedge clk) disable iff (reset) // [RULE3]
        (pll_mode && !busy && lock_s) |=> settled_q)
        else $error("settled flag missing with lock");
    a_fail_sets: assert property (@(posedge clk) disable iff (reset) // [RULE5]
        (monitor_on && fail_s) |=> fail_q && (clock_fail_event || $past(fail_q)))
        else $error("fail flag not set");
    a_drive_ignored: assert property (@(posedge clk) disable iff (reset) // [RULE7]
        !fuse_auxsrc |=> !aux_osc_high_power)
        else $error("drive bit acted on digital input");
    a_aux_enable: assert property (@(posedge clk) disable iff (reset) // [RULE8]
        auxen_q |=> aux_osc_en)
        else $error("aux oscillator off while enabled");
    a_redundant_abort: assert property (@(posedge clk) disable iff (reset) // [RULE14]
        (state_q == OSW_IDLE && req_q && next_q == cur_q) |=> !req_q && state_q == OSW_IDLE)
        else $error("redundant switch not aborted");
    a_ten_edges: assert property (@(posedge clk) disable iff (reset) // [RULE15]
        (state_q == OSW_SETTLE && state_d == OSW_DONE) |-> edges_q == `OSW_SETTLE_EDGES - 4'h1)
        else $error("switch before ten new-clock edges");
    a_switch_commit: assert property (@(posedge clk) disable iff (reset) // [RULE16]
        (state_q == OSW_DONE) |=> cur_q == $past(next_q) && !req_q)
        else $error("switch did not commit");
    a_fuse_holds_req: assert property (@(posedge clk) disable iff (reset) // [RULE17]
        fuse_swm |=> !req_q && state_q == OSW_IDLE)
        else $error("request live with switching disabled");
endmodule

// >>> sim/osw_osc_model.sv
// Behavioural model of the oscillator sources and PLL facing the switch block.
// Assumes it runs on the system clock and sees the block's registered enables.
`timescale 1ns/10ps
module osw_osc_model #(
    parameter int TMR_DLY = 30,
    parameter int PLL_DLY = 20
) (
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic [3:0] osc_en,
    input  wire logic       pll_en,
    output logic            pll_lock,
    output logic            startup_timer_done,
    output logic            new_clk
);
    logic [3:0] en_q;
    int         tmr_q;
    int         pll_q;
    logic [1:0] div_q;

    // Start-up timer restarts whenever the set of running oscillators changes
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            en_q  <= 4'h0;
            tmr_q <= 0;
        end else begin
            en_q  <= osc_en;
            tmr_q <= (en_q != osc_en) ? 0 : ((tmr_q < TMR_DLY) ? tmr_q + 1 : tmr_q);
        end
    end

    // PLL locks only after it has been enabled for a while, never instantly
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pll_q <= 0;
        end else begin
            pll_q <= !pll_en ? 0 : ((pll_q < PLL_DLY) ? pll_q + 1 : pll_q);
        end
    end

    // New clock is clk/8 and stands still until the oscillator has started
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            div_q   <= 2'h0;
            new_clk <= 1'b0;
        end else if (startup_timer_done) begin
            div_q   <= div_q + 2'h1;
            new_clk <= (div_q == 2'h3) ? !new_clk : new_clk;
        end
    end

    assign startup_timer_done = (tmr_q >= TMR_DLY);
    assign pll_lock           = (pll_q >= PLL_DLY);
endmodule

// >>> sim/tb_oscillator_switch_control.sv
// Self-checking bench for the oscillator switch block over Wishbone classic.
// Assumes the oscillator model drives timer, lock and new clock inputs.
`timescale 1ns/10ps
`include "osw_map.svh"
module tb_oscillator_switch_control;
    import osw_pkg::*;
    logic        clk, reset, wb_cyc, wb_stb, wb_we, wb_ack;
    logic [7:0]  wb_adr;
    logic [3:0]  wb_sel;
    logic [31:0] wb_dat_i, wb_dat_o, rv;
    logic [2:0]  src_fuse, clock_select;
    logic [1:0]  sub_fuse, main_osc_submode;
    logic        mon_fuse, aux_fuse, pll_lock, tmr_done, clock_failure, new_clk;
    logic        main_en, aux_en, fast_en, lowrc_en, pll_en, aux_hp, fail_ev;
    osw_state_t  switch_state;
    int          err_count, n_checks, settle_n, ev_n, s0;

    osw_ctrl uut (.clk(clk), .reset(reset), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack), .initial_source_fuse(src_fuse),
        .switch_monitor_fuse(mon_fuse), .aux_osc_source_fuse(aux_fuse),
        .main_osc_submode_fuse(sub_fuse), .pll_lock(pll_lock),
        .startup_timer_done(tmr_done), .clock_failure(clock_failure),
        .lowrc_keep(1'b0), .new_clk(new_clk), .clock_select(clock_select),
        .main_osc_en(main_en), .aux_osc_en(aux_en), .fast_rc_osc_en(fast_en),
        .low_power_rc_osc_en(lowrc_en), .pll_en(pll_en), .aux_osc_high_power(aux_hp),
        .main_osc_submode(main_osc_submode), .clock_fail_event(fail_ev),
        .switch_state(switch_state));

    osw_osc_model u_osc (.clk(clk), .reset(reset),
        .osc_en({main_en, aux_en, fast_en, lowrc_en}), .pll_en(pll_en),
        .pll_lock(pll_lock), .startup_timer_done(tmr_done), .new_clk(new_clk));

    // Clock at 100 MHz
    initial begin
        clk = 1'b0;
        forever #5 clk = !clk;
    end

    // Count settle-state cycles and fail events as they happen
    always @(posedge clk) begin
        if (switch_state === OSW_SETTLE) settle_n <= settle_n + 1;
        if (fail_ev === 1'b1) ev_n <= ev_n + 1;
    end

    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One classic cycle; held until ack is sampled high, released at that edge
    task automatic bus(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                       input logic [31:0] dat);
        int n = 0;
        @(posedge clk);
        wb_cyc   <= 1'b1;
        wb_stb   <= 1'b1;
        wb_we    <= we;
        wb_adr   <= adr;
        wb_sel   <= sel;
        wb_dat_i <= dat;
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack !== 1'b1 && n < 50);
        if (n >= 50) chk("bus ack", 32'h0, 32'h1);
        rv = wb_dat_o;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we  <= 1'b0;
    endtask

    task automatic wr(input logic [3:0] sel, input logic [31:0] dat);
        bus(1'b1, `OSW_ADR_CTRL, sel, dat);
    endtask

    task automatic rd();
        bus(1'b0, `OSW_ADR_CTRL, 4'hF, 32'h0);
    endtask

    // Poll until the request bit falls, bounded
    task automatic wait_done();
        for (int i = 0; i < 100; i++) begin
            rd();
            if (rv[0] === 1'b0) break;
        end
        chk("request cleared", {31'h0, rv[0]}, 32'h0);
    endtask

    task automatic wrap_up();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // Watchdog at 20000 cycles, well beyond the expected few hundred cycles
    initial begin
        #200000;
        err_count++;
        wrap_up();
    end

    initial begin
        {reset, wb_cyc, wb_stb, wb_we, clock_failure, mon_fuse} = 6'b100000;
        {wb_adr, wb_sel, wb_dat_i, settle_n, ev_n, err_count, n_checks} = '0;
        src_fuse = `OSW_SRC_MAIN;
        sub_fuse = 2'h2;
        aux_fuse = 1'b1;
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        repeat (4) @(posedge clk);
        rd();
        chk("reset value", rv, 32'h2200);
        chk("clock_select", clock_select, 3'h2);
        wr(4'h1, 32'h56);
        rd();
        chk("gaps, drive, enable", rv, 32'h2206);
        chk("aux enable", aux_en, 1'b1);
        chk("high power", aux_hp, 1'b1);
        aux_fuse <= 1'b0;
        repeat (4) @(posedge clk);
        chk("digital input", aux_hp, 1'b0);
        aux_fuse <= 1'b1;
        wr(4'h1, 32'h07);
        repeat (5) @(posedge clk);
        rd();
        chk("redundant switch", rv, 32'h2206);
        // Main to fast RC with PLL
        wr(4'h2, 32'h0100);
        s0 = settle_n;
        wr(4'h1, 32'h01);
        // Enable output is registered one cycle behind the bit
        @(posedge clk);
        chk("aux off", aux_en, 1'b0);
        wait_done();
        repeat (8) @(posedge clk);
        rd();
        chk("pll mode", rv, 32'h1120);
        chk("ten new clocks", {31'h0, (settle_n - s0) >= 72}, 32'h1);
        chk("sources", {clock_select, main_en, fast_en, pll_en}, 6'h0B);
        // Fast RC with PLL back to plain fast RC
        wr(4'h2, 32'h0000);
        wr(4'h1, 32'h01);
        rd();
        chk("settled in switch", {31'h0, rv[`OSW_B_SETTLED]}, 32'h0);
        wait_done();
        repeat (8) @(posedge clk);
        rd();
        chk("fast rc mode", rv, 32'h0000);
        chk("pll off", pll_en, 1'b0);
        // Monitor-detected failure
        clock_failure <= 1'b1;
        repeat (3) @(posedge clk);
        clock_failure <= 1'b0;
        repeat (6) @(posedge clk);
        rd();
        chk("fail flag", rv, 32'h0008);
        chk("fail event", ev_n, 1);
        wr(4'h1, 32'h00);
        rd();
        chk("fail cleared", rv, 32'h0000);
        bus(1'b1, 8'h04, 4'hF, 32'hFFFF);
        bus(1'b0, 8'h04, 4'hF, 32'h0);
        chk("unmapped read", rv, 32'h0);
        // Freeze with the monitor enabled
        wr(4'h1, 32'h80);
        wr(4'h2, 32'h0500);
        wr(4'h1, 32'h81);
        repeat (40) @(posedge clk);
        rd();
        chk("frozen", rv, 32'h0080);
        chk("frozen select", clock_select, 3'h0);
        // Switching disabled by the fuse
        mon_fuse <= 1'b1;
        src_fuse <= `OSW_SRC_LOWRC;
        repeat (6) @(posedge clk);
        wr(4'h1, 32'h01);
        rd();
        chk("fuse fields", {rv[14:12], rv[10:8], rv[0]}, 7'h5A);
        chk("fuse select", clock_select, 3'h5);
        chk("lowrc on", lowrc_en, 1'b1);
        chk("submode", main_osc_submode, 2'h2);
        wrap_up();
    end
endmodule
